// *** rtl/scd_switch_config.sv ***
// power-up switch configuration decoder with ahb-lite register slave
//
// Contract
// - switches are sampled once after power-up; later changes are ignored.
// - every switch off means default; all off gives all defaults.
// - memory switch off at power-up stores detected configuration as reference.
// - memory switch on compares reference with detected; mismatch raises diagnostic error.
// - bank one positions 2,3 choose internal bus rate 1M/500k/250k/125k.
// - static address is 192.168.x.n from bank one pos 8 and bank two.
// - bank two all on selects dhcp; address not kept across power loss.
// - bank two all off selects remote mode driven by server commands.
// - after enable command, address is requested again at every power-up.
// - after disable command, previous address is kept across power cycles.
// - bank three positions 1,2 choose 32/24/16/8 valve outputs.
// - bank three positions 3,4 choose 0/4/6/12 diagnostic input bytes.
// - on fieldbus fault or idle, outputs clear unless hold switch is on.
// - bank three 6 off autonegotiates; else 7 picks speed, 8 duplex.
// - bank one positions 4 to 7 have no effect.
//
// The AHB-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps

module scd_switch_config
  import scd_pkg::*;
(
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // switch pins, asynchronous
  input  wire logic [7:0]  switch_bank_one,
  input  wire logic [7:0]  switch_bank_two,
  input  wire logic [7:0]  switch_bank_three,
  // manifold configuration and nonvolatile store
  input  wire logic [31:0] unit_cfg,
  input  wire logic [31:0] nv_ref_cfg,
  input  wire logic        nv_dhcp_en,
  output logic             nv_cfg_wr,
  output logic [31:0]      nv_cfg_data,
  output logic             nv_dhcp_wr,
  output logic             nv_dhcp_data,
  // fieldbus side
  input  wire logic        bus_fault,
  input  wire logic [31:0] valve_in,
  input  wire logic        dhcp_cmd_enable,
  input  wire logic        dhcp_cmd_disable,
  output logic [31:0]      valve_out,
  // decoded settings
  output logic             cfg_valid,
  output logic [1:0]       baud_sel,
  output logic [31:0]      ip_addr,
  output scd_addr_mode_t   addr_mode,
  output logic             dhcp_request,
  output logic             retain_addr,
  output logic [2:0]       out_bytes,
  output logic [3:0]       diag_bytes,
  output logic             eth_auto,
  output logic             eth_100,
  output logic             eth_full,
  output logic             diag_err,
  // interrupt
  output logic             irq
);

  scd_state_t     st_ff;
  scd_state_t     nxt_st;
  scd_cfg_t       dec;
  logic [7:0]     b1;
  logic [7:0]     b2;
  logic [7:0]     b3;
  logic [31:0]    out_mask;
  logic [3:0]     ev;
  logic           addr_ok;
  logic [31:0]    rd_val;
  logic [31:0]    settings_word;
  logic [31:0]    sizes_word;

  assign b1 = st_ff.sync2[7:0];
  assign b2 = st_ff.sync2[15:8];
  assign b3 = st_ff.sync2[23:16];

  // decode of the synchronised switches; position off maps to code 0 = default
  always_comb begin
    dec            = '0;
    dec.cfg_mem_on = b1[SCD_B1_CFGMEM];
    dec.baud       = {b1[SCD_B1_BAUD_A], b1[SCD_B1_BAUD_B]};
    dec.octet3     = b1[SCD_B1_OCTET3];
    dec.octet4     = b2;
    if (&b2) begin
      dec.addr_mode = ADDR_DHCP;
    end else if (b2 == 8'h00) begin
      dec.addr_mode = ADDR_REMOTE;
    end else begin
      dec.addr_mode = ADDR_STATIC;
    end
    dec.vsel       = {b3[SCD_B3_VSEL_A], b3[SCD_B3_VSEL_B]};
    dec.diag_mode  = {b3[SCD_B3_DIAG_A], b3[SCD_B3_DIAG_B]};
    dec.hold       = b3[SCD_B3_HOLD];
    dec.eth_manual = b3[SCD_B3_MANUAL];
    dec.eth_100    = b3[SCD_B3_SPEED];
    dec.eth_full   = b3[SCD_B3_DUPLEX];
    // bank one positions 4..7 are never looked at
  end

  // settled outputs, all from the configuration flops except nv_cfg_data, which follows unit_cfg directly
  assign cfg_valid = st_ff.cfg_valid;
  assign baud_sel  = st_ff.cfg.baud;
  assign ip_addr   = {SCD_IP_OCT1, SCD_IP_OCT2, 7'h00, st_ff.cfg.octet3,
                      st_ff.cfg.octet4};
  assign addr_mode = st_ff.cfg.addr_mode;
  assign out_bytes = SCD_OUT_MAX - {1'b0, st_ff.cfg.vsel};
  assign eth_auto  = !st_ff.cfg.eth_manual;
  assign eth_100   = st_ff.cfg.eth_manual & st_ff.cfg.eth_100;
  assign eth_full  = st_ff.cfg.eth_manual & st_ff.cfg.eth_full;
  assign diag_err  = st_ff.diag_err;
  assign dhcp_request = st_ff.dhcp_request;
  assign retain_addr  = (st_ff.cfg.addr_mode == ADDR_REMOTE) && !st_ff.dhcp_en;
  assign nv_cfg_wr    = st_ff.nv_cfg_wr;
  assign nv_cfg_data  = unit_cfg;
  assign nv_dhcp_wr   = st_ff.nv_dhcp_wr;
  assign nv_dhcp_data = st_ff.dhcp_en;
  assign valve_out    = st_ff.valve_out;

  always_comb begin
    unique case (st_ff.cfg.diag_mode)
      2'b00:   diag_bytes = SCD_DIAG_B0;
      2'b01:   diag_bytes = SCD_DIAG_B1;
      2'b10:   diag_bytes = SCD_DIAG_B2;
      2'b11:   diag_bytes = SCD_DIAG_B3;
    endcase
  end

  // byte lanes beyond the selected output image are forced low
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_lane
      assign out_mask[gi*8 +: 8] = (gi < out_bytes) ? 8'hff : 8'h00;
    end
  endgenerate

  // bus side
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = st_ff.rdata;
  assign irq       = |(st_ff.irq_stat & st_ff.irq_mask);
  assign addr_ok   = hsel && htrans[1] && hready;

  assign settings_word = {9'h0, st_ff.cfg_valid, st_ff.cfg};
  assign sizes_word    = {16'h0, 2'h0, st_ff.phase, st_ff.dhcp_en, st_ff.diag_err,
                          1'b0, out_bytes, diag_bytes, retain_addr, dhcp_request};

  always_comb begin
    unique case (haddr[4:0])
      SCD_OFS_SETTINGS: rd_val = settings_word;
      SCD_OFS_IPADDR:   rd_val = ip_addr;
      SCD_OFS_IRQ_STAT: rd_val = {28'h0, st_ff.irq_stat};
      SCD_OFS_IRQ_MASK: rd_val = {28'h0, st_ff.irq_mask};
      SCD_OFS_SIZES:    rd_val = sizes_word;
      default:          rd_val = 32'h0;
    endcase
  end

  always_comb begin
    nxt_st            = st_ff;
    ev                = '0;
    nxt_st.sync1      = {switch_bank_three, switch_bank_two, switch_bank_one};
    nxt_st.sync2      = st_ff.sync1;
    nxt_st.nv_cfg_wr  = 1'b0;
    nxt_st.nv_dhcp_wr = 1'b0;
    nxt_st.fault_d    = bus_fault;

    unique case (st_ff.phase)
      PH_SETTLE: begin
        if (st_ff.settle_cnt == SCD_SETTLE_LAST) begin
          nxt_st.cfg       = dec;
          nxt_st.cfg_valid = 1'b1;
          nxt_st.dhcp_en   = nv_dhcp_en;
          nxt_st.phase     = PH_CHECK;
        end else begin
          nxt_st.settle_cnt = st_ff.settle_cnt + 9'h001;
        end
      end
      PH_CHECK: begin
        if (st_ff.cfg.cfg_mem_on) begin
          if (unit_cfg != nv_ref_cfg) begin
            nxt_st.diag_err = 1'b1;
            ev[SCD_EV_MISMATCH] = 1'b1;
          end
        end else begin
          nxt_st.nv_cfg_wr = 1'b1;
          ev[SCD_EV_STORED] = 1'b1;
        end
        unique case (st_ff.cfg.addr_mode)
          ADDR_DHCP:   nxt_st.dhcp_request = 1'b1;
          ADDR_REMOTE: nxt_st.dhcp_request = st_ff.dhcp_en;
          default:     nxt_st.dhcp_request = 1'b0;
        endcase
        nxt_st.phase = PH_RUN;
      end
      PH_RUN: begin
        if (st_ff.cfg.addr_mode == ADDR_REMOTE) begin
          if (dhcp_cmd_enable) begin
            nxt_st.dhcp_en    = 1'b1;
            nxt_st.nv_dhcp_wr = 1'b1;
            ev[SCD_EV_DHCP_CMD] = 1'b1;
          end else if (dhcp_cmd_disable) begin
            nxt_st.dhcp_en    = 1'b0;
            nxt_st.nv_dhcp_wr = 1'b1;
            ev[SCD_EV_DHCP_CMD] = 1'b1;
          end
        end
        if (bus_fault) begin
          if (!st_ff.cfg.hold) begin
            nxt_st.valve_out = 32'h0;
          end
        end else begin
          nxt_st.valve_out = valve_in & out_mask;
        end
      end
      default: nxt_st.phase = PH_SETTLE;
    endcase
    ev[SCD_EV_FAULT] = bus_fault && !st_ff.fault_d && (st_ff.phase == PH_RUN);

    // register writes land in the data phase
    nxt_st.wr_pend = addr_ok && hwrite;
    if (addr_ok) begin
      nxt_st.wr_addr = haddr[4:0];
      nxt_st.rdata   = hwrite ? 32'h0 : rd_val;
    end
    if (st_ff.wr_pend && st_ff.wr_addr == SCD_OFS_IRQ_STAT) begin
      nxt_st.irq_stat = st_ff.irq_stat & ~hwdata[3:0];
    end
    if (st_ff.wr_pend && st_ff.wr_addr == SCD_OFS_IRQ_MASK) begin
      nxt_st.irq_mask = hwdata[3:0];
    end
    // a new event wins over a clear in the same cycle
    nxt_st.irq_stat = nxt_st.irq_stat | ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_ff          <= '0;
      st_ff.phase    <= PH_SETTLE;
      st_ff.irq_mask <= SCD_MASK_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_cfg_frozen: assert property (
    (st_ff.phase == PH_RUN) |=> $stable(st_ff.cfg) && st_ff.cfg_valid)
    else $error("settings changed after capture");

  chk_settle_end: assert property (
    (st_ff.phase == PH_SETTLE && st_ff.settle_cnt == SCD_SETTLE_LAST)
      |=> (st_ff.phase == PH_CHECK) ##1 (st_ff.phase == PH_RUN))
    else $error("capture sequence out of step");

  chk_store_ref: assert property (
    (st_ff.phase == PH_CHECK && !st_ff.cfg.cfg_mem_on)
      |=> nv_cfg_wr ##1 !nv_cfg_wr)
    else $error("reference store pulse missing");

  chk_mismatch_err: assert property (
    (st_ff.phase == PH_CHECK && st_ff.cfg.cfg_mem_on && unit_cfg != nv_ref_cfg)
      |=> diag_err && !nv_cfg_wr)
    else $error("configuration mismatch not flagged");

  chk_static_ip: assert property (
    (cfg_valid && addr_mode == ADDR_STATIC)
      |-> ip_addr[7:0] != 8'h00 && ip_addr[7:0] != 8'hff && ip_addr[15:9] == 7'h00)
    else $error("static address out of range");

  chk_dhcp_power: assert property (
    (st_ff.phase == PH_CHECK && st_ff.cfg.addr_mode == ADDR_DHCP) |=> dhcp_request)
    else $error("dhcp mode did not request an address");

  chk_remote_en: assert property (
    (st_ff.phase == PH_RUN && addr_mode == ADDR_REMOTE && dhcp_cmd_enable)
      |=> nv_dhcp_wr && nv_dhcp_data && !retain_addr)
    else $error("enable command not recorded");

  chk_remote_dis: assert property (
    (st_ff.phase == PH_RUN && addr_mode == ADDR_REMOTE && !dhcp_cmd_enable
      && dhcp_cmd_disable) |=> nv_dhcp_wr && !nv_dhcp_data && retain_addr)
    else $error("disable command not recorded");

  chk_fault_clear: assert property (
    (st_ff.phase == PH_RUN && bus_fault && !st_ff.cfg.hold) |=> valve_out == 32'h0)
    else $error("outputs not cleared on fault");

  chk_fault_hold: assert property (
    (st_ff.phase == PH_RUN && bus_fault && st_ff.cfg.hold)
      |=> valve_out == $past(valve_out))
    else $error("outputs not held on fault");

  chk_out_lanes: assert property (
    (st_ff.cfg.vsel == 2'b11) |-> valve_out[31:8] == 24'h0)
    else $error("valve image wider than selected");

  chk_eth_auto: assert property (
    (cfg_valid && eth_auto) |-> !eth_100 && !eth_full)
    else $error("manual link bits leak in autonegotiation");

  chk_run_kept: assert property (
    (st_ff.phase == PH_RUN) |=> (st_ff.phase == PH_RUN))
    else $error("capture phase left run state");

  chk_settle_blank: assert property (
    (st_ff.phase == PH_SETTLE) |-> !cfg_valid && (st_ff.cfg == '0))
    else $error("settings visible before capture");

  chk_all_off: assert property (
    (st_ff.phase == PH_SETTLE && st_ff.settle_cnt == SCD_SETTLE_LAST && b1 == 8'h00
      && b3 == 8'h00) |=> baud_sel == 2'b00 && out_bytes == SCD_OUT_MAX
      && diag_bytes == SCD_DIAG_B0 && eth_auto && !st_ff.cfg.hold)
    else $error("all-off switches did not give defaults");

  chk_baud_take: assert property (
    (st_ff.phase == PH_SETTLE && st_ff.settle_cnt == SCD_SETTLE_LAST)
      |=> baud_sel == {$past(b1[SCD_B1_BAUD_A]), $past(b1[SCD_B1_BAUD_B])})
    else $error("bus rate not taken from switches");

  chk_ip_take: assert property (
    (st_ff.phase == PH_SETTLE && st_ff.settle_cnt == SCD_SETTLE_LAST)
      |=> ip_addr[7:0] == $past(b2) && ip_addr[8] == $past(b1[SCD_B1_OCTET3]))
    else $error("address octets not taken from switches");

  chk_static_nodhcp: assert property (
    (st_ff.phase == PH_CHECK && st_ff.cfg.addr_mode == ADDR_STATIC)
      |=> !dhcp_request && !retain_addr)
    else $error("static address asked for a server");

  chk_dhcp_code: assert property (
    (cfg_valid && ip_addr[7:0] == 8'hff) |-> addr_mode == ADDR_DHCP && !retain_addr)
    else $error("all-on bank two not in dhcp mode");

  chk_remote_code: assert property (
    (cfg_valid && ip_addr[7:0] == 8'h00) |-> addr_mode == ADDR_REMOTE)
    else $error("all-off bank two not in remote mode");

  chk_cmd_ignored: assert property (
    (st_ff.phase == PH_RUN && addr_mode != ADDR_REMOTE) |=> !nv_dhcp_wr)
    else $error("server command taken outside remote mode");

  chk_no_store: assert property (
    (st_ff.phase == PH_CHECK && st_ff.cfg.cfg_mem_on) |=> !nv_cfg_wr)
    else $error("reference overwritten in compare mode");

  chk_lanes_two: assert property (
    (out_bytes == 3'h2) |-> valve_out[31:16] == 16'h0)
    else $error("valve image wider than two bytes");

  chk_lanes_three: assert property (
    (out_bytes == 3'h3) |-> valve_out[31:24] == 8'h0)
    else $error("valve image wider than three bytes");

  chk_fault_event: assert property (
    (st_ff.phase == PH_RUN && bus_fault && !st_ff.fault_d)
      |=> st_ff.irq_stat[SCD_EV_FAULT])
    else $error("fault event not recorded");

endmodule

// *** rtl/scd_pkg.sv ***
// package for the switch configuration decoder: map, fields, timing
package scd_pkg;

  // bus map (byte addresses)
  localparam logic [4:0] SCD_OFS_SETTINGS = 5'h00;
  localparam logic [4:0] SCD_OFS_IPADDR   = 5'h04;
  localparam logic [4:0] SCD_OFS_IRQ_STAT = 5'h08;
  localparam logic [4:0] SCD_OFS_IRQ_MASK = 5'h0c;
  localparam logic [4:0] SCD_OFS_SIZES    = 5'h10;

  // interrupt status / mask bit positions
  localparam int SCD_EV_MISMATCH = 0;
  localparam int SCD_EV_STORED   = 1;
  localparam int SCD_EV_DHCP_CMD = 2;
  localparam int SCD_EV_FAULT    = 3;
  localparam int SCD_NUM_EV      = 4;
  localparam logic [3:0] SCD_MASK_RST = 4'h0;

  // switch positions inside each synchronised bank (position n -> bit n-1)
  localparam int SCD_B1_CFGMEM = 0;
  localparam int SCD_B1_BAUD_A = 1;
  localparam int SCD_B1_BAUD_B = 2;
  localparam int SCD_B1_OCTET3 = 7;
  localparam int SCD_B3_VSEL_A = 0;
  localparam int SCD_B3_VSEL_B = 1;
  localparam int SCD_B3_DIAG_A = 2;
  localparam int SCD_B3_DIAG_B = 3;
  localparam int SCD_B3_HOLD   = 4;
  localparam int SCD_B3_MANUAL = 5;
  localparam int SCD_B3_SPEED  = 6;
  localparam int SCD_B3_DUPLEX = 7;

  // fixed upper octets of a static address
  localparam logic [7:0] SCD_IP_OCT1 = 8'hc0;
  localparam logic [7:0] SCD_IP_OCT2 = 8'ha8;

  // diagnostic byte counts per mode 0..3, and the widest valve output image in bytes
  localparam logic [3:0] SCD_DIAG_B0 = 4'h0;
  localparam logic [3:0] SCD_DIAG_B1 = 4'h4;
  localparam logic [3:0] SCD_DIAG_B2 = 4'h6;
  localparam logic [3:0] SCD_DIAG_B3 = 4'hc;
  localparam logic [2:0] SCD_OUT_MAX = 3'h4;

  // switch settle time before the one-time capture
  localparam int CLK_MHZ          = 250;
  localparam int SCD_SETTLE_NS    = 1000;
  localparam int SCD_SETTLE_CYC   = (SCD_SETTLE_NS * CLK_MHZ + 999) / 1000;
  localparam logic [8:0] SCD_SETTLE_LAST = 9'(SCD_SETTLE_CYC - 1);

  typedef enum logic [1:0] {ADDR_STATIC, ADDR_DHCP, ADDR_REMOTE} scd_addr_mode_t;
  typedef enum logic [1:0] {PH_SETTLE, PH_CHECK, PH_RUN} scd_phase_t;

  typedef struct packed {
    logic           cfg_mem_on;
    logic [1:0]     baud;
    logic           octet3;
    logic [7:0]     octet4;
    scd_addr_mode_t addr_mode;
    logic [1:0]     vsel;
    logic [1:0]     diag_mode;
    logic           hold;
    logic           eth_manual;
    logic           eth_100;
    logic           eth_full;
  } scd_cfg_t;

  typedef struct packed {
    scd_phase_t       phase;
    logic [8:0]       settle_cnt;
    logic [23:0]      sync1;
    logic [23:0]      sync2;
    scd_cfg_t         cfg;
    logic             cfg_valid;
    logic             dhcp_en;
    logic             dhcp_request;
    logic             diag_err;
    logic             nv_cfg_wr;
    logic             nv_dhcp_wr;
    logic             fault_d;
    logic [31:0]      valve_out;
    logic [3:0]       irq_stat;
    logic [3:0]       irq_mask;
    logic             wr_pend;
    logic [4:0]       wr_addr;
    logic [31:0]      rdata;
  } scd_state_t;

endpackage

// *** bench/scd_nv_model.sv ***
// behavioural model of the nonvolatile store on the far side
`timescale 1ns/10ps

module scd_nv_model (
  // clock
  input  wire logic        hclk,
  // store writes from the device
  input  wire logic        nv_cfg_wr,
  input  wire logic [31:0] nv_cfg_data,
  input  wire logic        nv_dhcp_wr,
  input  wire logic        nv_dhcp_data,
  // stored values back to the device
  output logic [31:0]      nv_ref_cfg,
  output logic             nv_dhcp_en
);
  // contents survive device reset, as across a power cycle
  initial begin
    nv_ref_cfg = 32'h0000_0000;
    nv_dhcp_en = 1'b0;
  end
  always @(posedge hclk) begin
    if (nv_cfg_wr) begin
      nv_ref_cfg <= nv_cfg_data;
    end
    if (nv_dhcp_wr) begin
      nv_dhcp_en <= nv_dhcp_data;
    end
  end
endmodule

// *** bench/scd_switch_config_bench.sv ***
// self-checking bench for the switch configuration decoder
`timescale 1ns/10ps

module scd_switch_config_bench
  import scd_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, bus_fault, dhcp_cmd_enable;
  logic dhcp_cmd_disable, nv_cfg_wr, nv_dhcp_wr, nv_dhcp_data, nv_dhcp_en, cfg_valid;
  logic dhcp_request, retain_addr, eth_auto, eth_100, eth_full, diag_err, irq;
  logic [1:0] htrans, baud_sel;
  logic [2:0] hsize, out_bytes;
  logic [3:0] diag_bytes;
  logic [7:0] sw1, sw2, sw3;
  logic [31:0] haddr, hwdata, hrdata, unit_cfg, nv_ref_cfg, nv_cfg_data;
  logic [31:0] valve_in, valve_out, ip_addr, rd;
  scd_addr_mode_t addr_mode;
  int errors, compares, cycles;

  scd_switch_config scd_switch_config_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .switch_bank_one(sw1),
    .switch_bank_two(sw2), .switch_bank_three(sw3), .unit_cfg(unit_cfg),
    .nv_ref_cfg(nv_ref_cfg), .nv_dhcp_en(nv_dhcp_en), .nv_cfg_wr(nv_cfg_wr),
    .nv_cfg_data(nv_cfg_data), .nv_dhcp_wr(nv_dhcp_wr), .nv_dhcp_data(nv_dhcp_data),
    .bus_fault(bus_fault), .valve_in(valve_in), .dhcp_cmd_enable(dhcp_cmd_enable),
    .dhcp_cmd_disable(dhcp_cmd_disable), .valve_out(valve_out), .cfg_valid(cfg_valid),
    .baud_sel(baud_sel), .ip_addr(ip_addr), .addr_mode(addr_mode),
    .dhcp_request(dhcp_request), .retain_addr(retain_addr), .out_bytes(out_bytes),
    .diag_bytes(diag_bytes), .eth_auto(eth_auto), .eth_100(eth_100),
    .eth_full(eth_full), .diag_err(diag_err), .irq(irq));

  scd_nv_model scd_nv_model_i (
    .hclk(hclk), .nv_cfg_wr(nv_cfg_wr), .nv_cfg_data(nv_cfg_data),
    .nv_dhcp_wr(nv_dhcp_wr), .nv_dhcp_data(nv_dhcp_data),
    .nv_ref_cfg(nv_ref_cfg), .nv_dhcp_en(nv_dhcp_en));

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  task automatic give_verdict;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // run is far shorter than this ceiling
  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      give_verdict();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // only the cycle ceiling ends a wait that never sees ready
  task automatic bus_wait;
    do begin
      @(posedge hclk);
    end while (hreadyout !== 1'b1);
  endtask

  task automatic ahb(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {27'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    bus_wait();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    bus_wait();
    rd = hrdata;
  endtask

  task automatic power_up(input logic [7:0] b1, b2, b3, input logic [31:0] u);
    int n;
    @(posedge hclk);
    hresetn <= 1'b0;
    sw1 <= b1;
    sw2 <= b2;
    sw3 <= b3;
    unit_cfg <= u;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (cfg_valid !== 1'b1 && n < 400);
    repeat (3) @(posedge hclk);
    #1;
  endtask

  task automatic pulse_cmd(input logic en);
    @(posedge hclk);
    dhcp_cmd_enable <= en;
    dhcp_cmd_disable <= !en;
    @(posedge hclk);
    dhcp_cmd_enable <= 1'b0;
    dhcp_cmd_disable <= 1'b0;
    repeat (3) @(posedge hclk);
    #1;
  endtask

  task automatic t_defaults;
    power_up(8'h00, 8'h00, 8'h00, 32'h1357_9bdf);
    check(baud_sel, 2'd0);
    check({out_bytes, diag_bytes, eth_auto}, {3'd4, 4'h0, 1'b1});
    check(nv_ref_cfg, 32'h1357_9bdf);
    check(diag_err, 1'b0);
    @(posedge hclk);
    sw1 <= 8'hff;
    sw2 <= 8'h5a;
    sw3 <= 8'hff;
    repeat (5) @(posedge hclk);
    #1;
    check({baud_sel, out_bytes, eth_auto}, {2'd0, 3'd4, 1'b1});
    check({30'h0, addr_mode}, ADDR_REMOTE);
  endtask

  task automatic t_memory;
    power_up(8'h01, 8'h00, 8'h00, 32'h1357_9bdf);
    check(diag_err, 1'b0);
    power_up(8'h01, 8'h00, 8'h00, 32'h1357_9bde);
    check(diag_err, 1'b1);
    check(nv_ref_cfg, 32'h1357_9bdf);
  endtask

  task automatic t_tables;
    logic [7:0] n;
    logic [3:0] dtab [4];
    dtab = '{4'h0, 4'h4, 4'h6, 4'hc};
    for (int k = 0; k < 8; k++) begin
      n = (k == 7) ? 8'd254 : 8'(k * 36 + 1);
      power_up({k[2], {4{k[0]}}, k[0], k[1], 1'b0}, n,
               {k[2], k[1], k[0], 1'b0, k[0], k[1], k[0], k[1]}, 32'h0);
      check(baud_sel, k[1:0]);
      check(ip_addr, {8'hc0, 8'ha8, 7'h0, k[2], n});
      check({30'h0, addr_mode}, ADDR_STATIC);
      check(out_bytes, 3'(4 - k[1:0]));
      check(diag_bytes, dtab[k[1:0]]);
      check({eth_auto, eth_100, eth_full}, {!k[0], k[0] & k[1], k[0] & k[2]});
    end
  endtask

  task automatic t_dhcp;
    power_up(8'h80, 8'hff, 8'h00, 32'h0);
    check({30'h0, addr_mode}, ADDR_DHCP);
    check(retain_addr, 1'b0);
    pulse_cmd(1'b1);
    check(nv_dhcp_en, 1'b0);
    power_up(8'h00, 8'h00, 8'h00, 32'h0);
    check({30'h0, addr_mode}, ADDR_REMOTE);
    pulse_cmd(1'b1);
    check(nv_dhcp_en, 1'b1);
    power_up(8'h80, 8'h00, 8'h00, 32'h0);
    check({dhcp_request, retain_addr}, 2'b10);
    pulse_cmd(1'b0);
    check(nv_dhcp_en, 1'b0);
    power_up(8'h00, 8'h00, 8'h00, 32'h0);
    check({dhcp_request, retain_addr}, 2'b01);
  endtask

  task automatic t_outputs;
    for (int h = 0; h < 2; h++) begin
      power_up(8'h00, 8'h01, {3'b000, h[0], 4'b0011}, 32'h0);
      @(posedge hclk);
      valve_in <= 32'ha5c3_7e19;
      repeat (3) @(posedge hclk);
      #1;
      check(valve_out, 32'h0000_0019);
      @(posedge hclk);
      bus_fault <= 1'b1;
      valve_in <= 32'h1234_5678;
      repeat (3) @(posedge hclk);
      #1;
      check(valve_out, h[0] ? 32'h0000_0019 : 32'h0);
      @(posedge hclk);
      bus_fault <= 1'b0;
    end
  endtask

  task automatic t_irq;
    power_up(8'h00, 8'h00, 8'h00, 32'h2468_ace0);
    ahb(1'b0, SCD_OFS_IRQ_STAT, 32'h0);
    check(rd, 32'h0000_0002);
    ahb(1'b0, SCD_OFS_SETTINGS, 32'h0);
    check(rd[22], 1'b1);
    check(rd[21:0], 22'h00_0200);
    check(hresp, 1'b0);
    ahb(1'b0, 5'h14, 32'h0);
    check(rd, 32'h0);
    ahb(1'b0, SCD_OFS_SIZES, 32'h0);
    check(rd, 32'h0000_2102);
    ahb(1'b1, SCD_OFS_IRQ_MASK, 32'h2);
    #1;
    check(irq, 1'b1);
    ahb(1'b1, SCD_OFS_IRQ_STAT, 32'h2);
    #1;
    check(irq, 1'b0);
    ahb(1'b0, SCD_OFS_IRQ_MASK, 32'h0);
    check(rd, 32'h0000_0002);
  endtask

  initial begin
    errors = 0;
    compares = 0;
    cycles = 0;
    hresetn = 1'b0;
    {hsel, hwrite, bus_fault, dhcp_cmd_enable, dhcp_cmd_disable} = 5'h00;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    {sw1, sw2, sw3} = 24'h0;
    unit_cfg = 32'h0;
    valve_in = 32'h0;
    t_defaults();
    t_memory();
    t_tables();
    t_dhcp();
    t_outputs();
    t_irq();
    give_verdict();
  end
endmodule
